// ### src/pcc_console.v
// paging console control: keys, arbitration, lamps, register slave
// Functional notes
// - zone key toggles zone and its lamp
// - lower priority busy: slow blink, may pre-empt
// - higher priority busy: fast blink, discard request
// - call lasts while talk held, lamp steady
// - selection kept after talk; clear deselects
// - pre-chime lamp lit while pre-chime sent
// - select-all selects all, lights all lamps; pressed again, clears all
// - direct-call keys start call without talk
// - chime key starts chime, priority 6 or 7
// - directing console priority 10 outranks all
// - message key plays message, priority 2..8
// - alarm key alarms all zones, priority 7..9
// - alarm ends on stop or second press
// - second alarm to selection, reselect allowed
// - alarm allowed always; shown on all consoles
// - stop cancels own chime, message or alarm; director stop in idle only clears busy blink
// - standby lamp off, boot blink, ready steady
// - power off needs one second hold
// - alarm key or input boots from standby
// - music mode toggles music zones, clear erases
// - music mode ends on key or timeout
// - single-program: music dims during a call only, not during chime, message or alarm
`timescale 1ns/100ps
`include "pcc_defines.vh"
module pcc_console #(
  parameter NZ = 10,
  parameter BOOT_CYC = `PCC_BOOT_MS * `PCC_CLK_KHZ,
  parameter OFF_CYC = `PCC_OFF_HOLD_MS * `PCC_CLK_KHZ,
  parameter MUSIC_CYC = `PCC_MUSIC_TO_MS * `PCC_CLK_KHZ,
  parameter SLOW_CYC = `PCC_SLOW_MS * `PCC_CLK_KHZ,
  parameter FAST_CYC = `PCC_FAST_MS * `PCC_CLK_KHZ
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // operator keys, level while pressed
  input wire [NZ-1:0] zone_key,
  input wire all_key,
  input wire clear_key,
  input wire chime_key,
  input wire text_key,
  input wire talk_key,
  input wire power_key,
  input wire stop_key,
  input wire music_key,
  input wire alarm_key,
  input wire salarm_key,
  // central unit status
  input wire [NZ-1:0] zone_busy,
  input wire [3:0] busy_prio,
  input wire ext_alarm,
  input wire sys_ready,
  input wire alarm_active_any,
  input wire chime_done,
  input wire text_done,
  // requests to central unit
  output reg [2:0] ev_kind,
  output reg [3:0] ev_prio,
  output reg [NZ-1:0] ev_zones,
  output reg power_on_req,
  output reg music_dim,
  output reg [NZ-1:0] music_zones,
  // lamps
  output reg [NZ-1:0] zone_lamp,
  output reg all_lamp,
  output reg zone_occupied_lamp,
  output reg chime_lamp,
  output reg text_lamp,
  output reg alarm_lamp,
  output reg music_lamp,
  output reg power_lamp
);
  localparam ST_IDLE = 3'h0;
  localparam ST_CALL = 3'h1;
  localparam ST_CHIME = 3'h2;
  localparam ST_TEXT = 3'h3;
  localparam ST_ALARM = 3'h4;
  localparam PW_OFF = 2'h0;
  localparam PW_BOOT = 2'h1;
  localparam PW_ON = 2'h2;
  localparam [NZ-1:0] ALLZ = {NZ{1'b1}};

  reg [2:0] st_reg;
  reg [1:0] pw_reg;
  reg [NZ-1:0] sel_reg;
  reg [NZ-1:0] mus_reg;
  reg [NZ-1:0] direct_reg;
  reg [3:0] ctrl_reg;
  reg [3:0] txtpri_reg;
  reg [3:0] almpri_reg;
  reg music_mode_reg;
  reg sel_alarm_reg;
  reg pregong_reg;
  reg [1:0] blink_reg;
  reg [31:0] tmr_reg;
  reg [31:0] off_cnt_reg;
  reg [31:0] slow_cnt_reg;
  reg [31:0] fast_cnt_reg;
  reg slow_ph_reg;
  reg fast_ph_reg;
  reg [NZ-1:0] zk_d;
  reg [8:0] fk_d;
  reg clr_d;
  reg [NZ-1:0] zone_press;
  reg [8:0] fk_press;
  reg [3:0] my_prio;
  reg [2:0] want;
  reg [NZ-1:0] want_z;
  reg lower_busy;
  reg higher_busy;
  reg [31:0] rd_data;
  wire [8:0] fk;
  wire all_p, clr_p, chm_p, txt_p, talk_p, pwr_p, stop_p, mus_p, alm_p;
  wire salm_p;
  wire director;
  wire wb_req;
  wire [NZ-1:0] direct_hit;
  wire any_fn;

  assign fk = {salarm_key, alarm_key, music_key, stop_key, power_key,
    talk_key, text_key, chime_key, all_key};
  assign all_p = fk_press[0];
  assign chm_p = fk_press[1];
  assign txt_p = fk_press[2];
  assign talk_p = fk_press[3];
  assign pwr_p = fk_press[4];
  assign stop_p = fk_press[5];
  assign mus_p = fk_press[6];
  assign alm_p = fk_press[7];
  assign salm_p = fk_press[8];
  assign clr_p = clear_key & ~clr_d;
  assign director = ctrl_reg[`PCC_CTRL_DIRECTOR];
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign direct_hit = zone_press & direct_reg;
  assign any_fn = all_p | clr_p | chm_p | txt_p | stop_p | alm_p | salm_p;

  // rising edge detection of keys
  always @*
  begin
    zone_press = zone_key & ~zk_d;
    fk_press = fk & ~fk_d;
  end

  // priority of the request the operator is making
  always @*
  begin
    want = `PCC_EV_NONE;
    want_z = sel_reg;
    my_prio = `PCC_PRI_CALL;
    if (chm_p)
    begin
      want = `PCC_EV_CHIME;
      my_prio = ctrl_reg[`PCC_CTRL_CHIME7] ? 4'h7 : 4'h6;
    end
    else if (txt_p)
    begin
      want = `PCC_EV_TEXT;
      my_prio = txtpri_reg;
    end
    else if (talk_p || (|direct_hit))
      want = `PCC_EV_CALL;
    if (director)
      my_prio = `PCC_PRI_DIRECTOR;
  end

  // compare against occupied zones; equal never pre-empts
  always @*
  begin
    lower_busy = 1'b0;
    higher_busy = 1'b0;
    if (|(want_z & zone_busy))
    begin
      if (busy_prio >= my_prio)
        higher_busy = 1'b1;
      else
        lower_busy = 1'b1;
    end
  end

  // blink dividers, one-cycle enables toggle phases
  always @(posedge clk)
  begin
    if (rst)
    begin
      slow_cnt_reg <= 32'h0;
      fast_cnt_reg <= 32'h0;
      slow_ph_reg <= 1'b0;
      fast_ph_reg <= 1'b0;
    end
    else
    begin
      slow_cnt_reg <= (slow_cnt_reg >= SLOW_CYC - 1) ? 32'h0
        : slow_cnt_reg + 32'h1;
      fast_cnt_reg <= (fast_cnt_reg >= FAST_CYC - 1) ? 32'h0
        : fast_cnt_reg + 32'h1;
      if (slow_cnt_reg >= SLOW_CYC - 1)
        slow_ph_reg <= ~slow_ph_reg;
      if (fast_cnt_reg >= FAST_CYC - 1)
        fast_ph_reg <= ~fast_ph_reg;
    end
  end

  // main control: power, selection, events, music mode
  always @(posedge clk)
  begin
    if (rst)
    begin
      zk_d <= {NZ{1'b0}};
      fk_d <= 9'h000;
      clr_d <= 1'b0;
      st_reg <= ST_IDLE;
      pw_reg <= PW_OFF;
      sel_reg <= {NZ{1'b0}};
      mus_reg <= {NZ{1'b0}};
      music_mode_reg <= 1'b0;
      sel_alarm_reg <= 1'b0;
      pregong_reg <= 1'b0;
      blink_reg <= 2'h0;
      tmr_reg <= 32'h0;
      off_cnt_reg <= 32'h0;
    end
    else
    begin
      zk_d <= zone_key;
      fk_d <= fk;
      clr_d <= clear_key;
      // power sequencing
      case (pw_reg)
        PW_OFF:
        begin
          if (pwr_p || alm_p || salm_p || ext_alarm)
          begin
            pw_reg <= PW_BOOT;
            tmr_reg <= 32'h0;
          end
        end
        PW_BOOT:
        begin
          tmr_reg <= tmr_reg + 32'h1;
          if (sys_ready || tmr_reg >= BOOT_CYC - 1)
            pw_reg <= PW_ON;
        end
        PW_ON:
        begin
          // hold for the full second; a short tap does nothing
          if (power_key && st_reg != ST_ALARM)
          begin
            off_cnt_reg <= off_cnt_reg + 32'h1;
            if (off_cnt_reg >= OFF_CYC - 1)
            begin
              pw_reg <= PW_OFF;
              st_reg <= ST_IDLE;
              off_cnt_reg <= 32'h0;
            end
          end
          else
            off_cnt_reg <= 32'h0;
        end
        default:
          pw_reg <= PW_OFF;
      endcase
      // music assign mode
      if (music_mode_reg)
      begin
        tmr_reg <= tmr_reg + 32'h1;
        if (mus_p || any_fn || talk_p || tmr_reg >= MUSIC_CYC - 1)
          music_mode_reg <= 1'b0;
        mus_reg <= clr_p ? {NZ{1'b0}} : mus_reg ^ zone_press;
      end
      else if (mus_p && pw_reg == PW_ON && st_reg == ST_IDLE)
      begin
        music_mode_reg <= 1'b1;
        tmr_reg <= 32'h0;
      end
      else
      begin
        // selection kept until changed
        if (clr_p)
          sel_reg <= {NZ{1'b0}};
        else if (all_p)
          sel_reg <= (sel_reg == ALLZ) ? {NZ{1'b0}} : ALLZ;
        else
          sel_reg <= sel_reg ^ zone_press;
      end
      // event state machine
      case (st_reg)
        ST_IDLE:
        begin
          if (alm_p || ext_alarm)
          begin
            st_reg <= ST_ALARM;
            sel_alarm_reg <= 1'b0;
          end
          else if (salm_p)
          begin
            st_reg <= ST_ALARM;
            sel_alarm_reg <= 1'b1;
          end
          else if (pw_reg == PW_ON && !music_mode_reg && want != 3'h0)
          begin
            blink_reg <= {higher_busy, lower_busy};
            if (!higher_busy)
            begin
              if (want == `PCC_EV_CHIME)
                st_reg <= ST_CHIME;
              else if (want == `PCC_EV_TEXT)
                st_reg <= ST_TEXT;
              else
              begin
                st_reg <= ST_CALL;
                pregong_reg <= ctrl_reg[`PCC_CTRL_PREGONG];
              end
            end
          end
          else if (want == 3'h0 && zone_press == {NZ{1'b0}})
            blink_reg <= {higher_busy, lower_busy};
        end
        ST_CALL:
        begin
          if (chime_done)
            pregong_reg <= 1'b0;
          if (!talk_key && !(|(zone_key & direct_reg)))
          begin
            st_reg <= ST_IDLE;
            pregong_reg <= 1'b0;
          end
        end
        ST_CHIME:
          if (chime_done || stop_p)
            st_reg <= ST_IDLE;
        ST_TEXT:
          if (text_done || stop_p)
            st_reg <= ST_IDLE;
        ST_ALARM:
          if (stop_p || (sel_alarm_reg ? salm_p : alm_p))
            st_reg <= ST_IDLE;
        default:
          st_reg <= ST_IDLE;
      endcase
      // an alarm may interrupt any running call, chime or message
      if ((st_reg == ST_CALL || st_reg == ST_CHIME || st_reg == ST_TEXT)
        && (alm_p || salm_p || ext_alarm))
      begin
        st_reg <= ST_ALARM;
        sel_alarm_reg <= salm_p & ~alm_p & ~ext_alarm;
        pregong_reg <= 1'b0;
      end
      if (st_reg == ST_IDLE && director && stop_p)
        blink_reg <= 2'h0;
    end
  end

  // register decode for reads
  always @*
  begin
    rd_data = 32'h0;
    case (wb_adr_i)
      `PCC_OFS_CTRL: rd_data[3:0] = ctrl_reg;
      `PCC_OFS_ZSEL: rd_data[NZ-1:0] = direct_reg;
      `PCC_OFS_MUSIC: rd_data[NZ-1:0] = mus_reg;
      `PCC_OFS_STAT: rd_data[7:0] = {music_mode_reg, pw_reg, st_reg,
        blink_reg};
      `PCC_OFS_PRIO: rd_data[7:0] = {almpri_reg, txtpri_reg};
      `PCC_OFS_BUSY: rd_data[NZ-1:0] = sel_reg;
      default: rd_data = 32'h0;
    endcase
  end

  // wishbone slave: one wait state, unmapped reads zero
  always @(posedge clk)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      ctrl_reg <= `PCC_CTRL_RST;
      txtpri_reg <= `PCC_TXTPRI_RST;
      almpri_reg <= `PCC_ALMPRI_RST;
      direct_reg <= {NZ{1'b0}};
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_data : 32'h0;
      if (wb_req && wb_we_i && wb_sel_i[0])
      begin
        case (wb_adr_i)
          `PCC_OFS_CTRL: ctrl_reg <= wb_dat_i[3:0];
          `PCC_OFS_ZSEL: direct_reg <= wb_dat_i[NZ-1:0];
          `PCC_OFS_PRIO:
          begin
            // out-of-range priorities are clamped to the legal span
            if (wb_dat_i[3:0] < 4'h2)
              txtpri_reg <= 4'h2;
            else if (wb_dat_i[3:0] > 4'h8)
              txtpri_reg <= 4'h8;
            else
              txtpri_reg <= wb_dat_i[3:0];
            if (wb_dat_i[7:4] < 4'h7)
              almpri_reg <= 4'h7;
            else if (wb_dat_i[7:4] > 4'h9)
              almpri_reg <= 4'h9;
            else
              almpri_reg <= wb_dat_i[7:4];
          end
          default: ;
        endcase
      end
    end
  end

  // outputs to central unit and lamps, all registered
  always @(posedge clk)
  begin
    if (rst)
    begin
      ev_kind <= 3'h0;
      ev_prio <= 4'h0;
      ev_zones <= {NZ{1'b0}};
      power_on_req <= 1'b0;
      music_dim <= 1'b0;
      music_zones <= {NZ{1'b0}};
      zone_lamp <= {NZ{1'b0}};
      all_lamp <= 1'b0;
      zone_occupied_lamp <= 1'b0;
      chime_lamp <= 1'b0;
      text_lamp <= 1'b0;
      alarm_lamp <= 1'b0;
      music_lamp <= 1'b0;
      power_lamp <= 1'b0;
    end
    else
    begin
      power_on_req <= (pw_reg != PW_OFF);
      power_lamp <= (pw_reg == PW_ON)
        | ((pw_reg == PW_BOOT) & slow_ph_reg);
      music_zones <= mus_reg;
      music_dim <= ctrl_reg[`PCC_CTRL_SINGLEPRG] & (st_reg == ST_CALL);
      music_lamp <= music_mode_reg;
      zone_lamp <= music_mode_reg ? mus_reg : sel_reg;
      all_lamp <= ~music_mode_reg & (sel_reg == ALLZ);
      chime_lamp <= (st_reg == ST_CHIME) | pregong_reg;
      text_lamp <= (st_reg == ST_TEXT);
      alarm_lamp <= (st_reg == ST_ALARM) | alarm_active_any;
      if (st_reg == ST_CALL)
        zone_occupied_lamp <= 1'b1;
      else if (blink_reg[1])
        zone_occupied_lamp <= fast_ph_reg;
      else if (blink_reg[0])
        zone_occupied_lamp <= slow_ph_reg;
      else
        zone_occupied_lamp <= 1'b0;
      case (st_reg)
        ST_CALL:
        begin
          ev_kind <= `PCC_EV_CALL;
          ev_prio <= director ? `PCC_PRI_DIRECTOR : `PCC_PRI_CALL;
          ev_zones <= sel_reg;
        end
        ST_CHIME:
        begin
          ev_kind <= `PCC_EV_CHIME;
          ev_prio <= director ? `PCC_PRI_DIRECTOR
            : (ctrl_reg[`PCC_CTRL_CHIME7] ? 4'h7 : 4'h6);
          ev_zones <= sel_reg;
        end
        ST_TEXT:
        begin
          ev_kind <= `PCC_EV_TEXT;
          ev_prio <= director ? `PCC_PRI_DIRECTOR : txtpri_reg;
          ev_zones <= sel_reg;
        end
        ST_ALARM:
        begin
          ev_kind <= sel_alarm_reg ? `PCC_EV_SALARM : `PCC_EV_ALARM;
          ev_prio <= director ? `PCC_PRI_DIRECTOR : almpri_reg;
          // selective alarm keeps the zones latched from the selection at its key press
          ev_zones <= sel_alarm_reg ? ev_zones : ALLZ;
        end
        default:
        begin
          ev_kind <= `PCC_EV_NONE;
          ev_prio <= `PCC_PRI_MUSIC;
          ev_zones <= {NZ{1'b0}};
        end
      endcase
      if (st_reg != ST_ALARM && salm_p)
        ev_zones <= sel_reg;
    end
  end
endmodule // pcc_console

// ### common/pcc_defines.vh
// constants for the paging console control block
`ifndef PCC_DEFINES_VH
`define PCC_DEFINES_VH
// register byte offsets
`define PCC_OFS_CTRL 8'h00
`define PCC_OFS_ZSEL 8'h04
`define PCC_OFS_MUSIC 8'h08
`define PCC_OFS_STAT 8'h0C
`define PCC_OFS_PRIO 8'h10
`define PCC_OFS_BUSY 8'h14
`define PCC_OFS_KEYS 8'h18
`define PCC_OFS_CMD 8'h1C
// ctrl register fields
`define PCC_CTRL_PREGONG 0
`define PCC_CTRL_DIRECTOR 1
`define PCC_CTRL_SINGLEPRG 2
`define PCC_CTRL_CHIME7 3
// reset values
`define PCC_CTRL_RST 4'h0
`define PCC_TXTPRI_RST 4'h5
`define PCC_ALMPRI_RST 4'h8
// fixed priorities
`define PCC_PRI_MUSIC 4'h1
`define PCC_PRI_CALL 4'h5
`define PCC_PRI_DIRECTOR 4'hA
// event kinds sent to the central unit
`define PCC_EV_NONE 3'h0
`define PCC_EV_CALL 3'h1
`define PCC_EV_CHIME 3'h2
`define PCC_EV_TEXT 3'h3
`define PCC_EV_ALARM 3'h4
`define PCC_EV_SALARM 3'h5
// timing, in ms, and clock rate in kHz
`define PCC_CLK_KHZ 40000
`define PCC_BOOT_MS 10000
`define PCC_OFF_HOLD_MS 1000
`define PCC_MUSIC_TO_MS 15000
`define PCC_SLOW_MS 500
`define PCC_FAST_MS 100
`endif

// ### verif/pcc_props.sv
// port checker for the paging console control
`timescale 1ns/100ps
`include "pcc_defines.vh"
module pcc_props #(
  parameter NZ = 10
) (
  // clock, reset and bus
  input wire clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  // talk key and requests
  input wire talk_key,
  input wire [2:0] ev_kind,
  input wire [3:0] ev_prio,
  input wire [NZ-1:0] ev_zones,
  // lamps
  input wire zone_occupied_lamp,
  input wire alarm_lamp,
  input wire power_lamp
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  AST_ACK_NEXT:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  AST_ACK_ONE:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_ACK_IDLE:
    assert property (!wb_stb_i |=> !wb_ack_o) else $error("stray ack");
  AST_RST_QUIET:
    assert property ($fell(rst) |-> ev_kind == 3'h0 && !power_lamp)
    else $error("not idle after reset");
  AST_CALL_LAMP:
    assert property (ev_kind == `PCC_EV_CALL |-> zone_occupied_lamp)
    else $error("busy lamp off in call");
  AST_TALK_END:
    assert property ($fell(talk_key) && ev_kind == `PCC_EV_CALL
      |-> ##[1:3] ev_kind != `PCC_EV_CALL) else $error("call kept");
  AST_CALL_PRIO:
    assert property (ev_kind == `PCC_EV_CALL |-> ev_prio == `PCC_PRI_CALL
      || ev_prio == `PCC_PRI_DIRECTOR) else $error("call priority");
  AST_CHIME_PRIO:
    assert property (ev_kind == `PCC_EV_CHIME |-> ev_prio inside {6, 7})
    else $error("chime priority");
  AST_TEXT_PRIO:
    assert property (ev_kind == `PCC_EV_TEXT |-> ev_prio inside {[2:8]})
    else $error("message priority");
  AST_ALARM_ALL:
    assert property (ev_kind == `PCC_EV_ALARM
      |-> &ev_zones && ev_prio inside {[7:9]}) else $error("alarm request");
  AST_ALARM_LAMP:
    assert property (ev_kind == `PCC_EV_ALARM ##1 ev_kind == `PCC_EV_ALARM
      |-> alarm_lamp) else $error("alarm lamp off");
  // main scenarios
  cover property (ev_kind == `PCC_EV_CALL);
  cover property (ev_kind == `PCC_EV_CHIME);
  cover property (ev_kind == `PCC_EV_ALARM);
endmodule // pcc_props
bind pcc_console pcc_props #(.NZ(NZ)) pcc_props_inst (.clk(clk),
  .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .talk_key(talk_key), .ev_kind(ev_kind),
  .ev_prio(ev_prio), .ev_zones(ev_zones),
  .zone_occupied_lamp(zone_occupied_lamp), .alarm_lamp(alarm_lamp),
  .power_lamp(power_lamp));

// ### verif/pcc_central.sv
// behavioural central unit facing the console
`timescale 1ns/100ps
`include "pcc_defines.vh"
module pcc_central #(
  parameter NZ = 4,
  parameter BOOT_WAIT = 10,
  parameter PLAY_WAIT = 30
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // console requests and bench occupancy
  input wire [2:0] ev_kind,
  input wire power_on_req,
  input wire [NZ-1:0] busy_set,
  input wire [3:0] prio_set,
  // status back to the console
  output reg [NZ-1:0] zone_busy,
  output reg [3:0] busy_prio,
  output reg sys_ready,
  output reg alarm_active_any,
  output reg chime_done,
  output reg text_done
);
  integer boot_cnt;
  integer play_cnt;
  // ready only after a boot delay; drops with the power request
  always @(posedge clk)
  begin
    if (rst || !power_on_req)
      boot_cnt <= 0;
    else if (boot_cnt < BOOT_WAIT)
      boot_cnt <= boot_cnt + 1;
    sys_ready <= !rst && power_on_req && boot_cnt == BOOT_WAIT;
  end
  // occupancy, alarm indication and end of playback
  always @(posedge clk)
  begin
    zone_busy <= busy_set;
    busy_prio <= prio_set;
    alarm_active_any <= ev_kind == `PCC_EV_ALARM;
    if (ev_kind == `PCC_EV_CHIME || ev_kind == `PCC_EV_TEXT)
      play_cnt <= play_cnt + 1;
    else
      play_cnt <= 0;
    // one pulse only, so a late repeat cannot end a later event
    chime_done <= play_cnt == PLAY_WAIT && ev_kind == `PCC_EV_CHIME;
    text_done <= play_cnt == PLAY_WAIT && ev_kind == `PCC_EV_TEXT;
  end
endmodule // pcc_central

// ### verif/pcc_console_tb_top.sv
// self-checking bench for the paging console control
`timescale 1ns/100ps
`include "pcc_defines.vh"
`define CHK(a, e) \
  begin \
    comparisons++; \
    if ((a) !== (e)) \
    begin \
      fail_count++; \
      $display("mismatch at %0t got %h exp %h", $time, a, e); \
    end \
  end
module pcc_console_tb_top;
  localparam NZ = 4;
  // idle request word: no event, music priority, no zones
  localparam [31:0] IDLE_W = {21'h0, `PCC_EV_NONE, `PCC_PRI_MUSIC, 4'h0};
  // drivers
  reg clk = 1'h0;
  reg rst = 1'h1;
  reg cyc = 1'h0;
  reg stb = 1'h0;
  reg we = 1'h0;
  reg [7:0] adr = 8'h00;
  reg [31:0] dwr = 32'h0;
  reg [13:0] kv = 14'h0;
  reg [NZ-1:0] bz = 4'h0;
  reg [3:0] bp = 4'h0;
  reg probe = 1'h0;
  reg [1:0] psel = 2'h0;
  reg [3:0] bsel = 4'hF;
  reg ext_al = 1'h0;
  reg [3:0] sel;
  reg [31:0] got;
  reg [31:0] expv;
  reg [31:0] exp_q[$];
  integer seed = 22500;
  integer i;
  integer fail_count = 0;
  integer comparisons = 0;
  // design outputs and partner status
  wire [31:0] dat;
  wire [2:0] ev_kind;
  wire [3:0] ev_prio, busy_prio;
  wire [NZ-1:0] ev_zones, zone_busy, zone_lamp;
  wire ack, pwr_req, dim, all_lamp, occ, chime_lamp, text_lamp;
  wire alarm_lamp, power_lamp, ready, alarm_any, chime_done, text_done;
  wire [NZ-1:0] mus_z;
  wire mus_lamp;
  // observed group chosen by the probe
  wire [31:0] obs = psel == 2'h0 ? {21'h0, ev_kind, ev_prio, ev_zones} :
    psel == 2'h1 ? {27'h0, zone_lamp, all_lamp} :
    psel == 2'h2 ? {24'h0, mus_lamp, mus_z, alarm_lamp, chime_lamp,
      text_lamp} :
    {28'h0, power_lamp, pwr_req, occ, dim};
  // short counts keep the run brief
  pcc_console #(.NZ(NZ), .BOOT_CYC(50), .OFF_CYC(20), .MUSIC_CYC(40),
    .SLOW_CYC(8), .FAST_CYC(2)) pcc_console_inst (.clk(clk), .rst(rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(bsel), .wb_dat_i(dwr), .wb_dat_o(dat), .wb_ack_o(ack),
    .zone_key(kv[3:0]), .all_key(kv[4]), .clear_key(kv[5]),
    .chime_key(kv[6]), .text_key(kv[7]), .talk_key(kv[8]),
    .power_key(kv[9]), .stop_key(kv[10]), .music_key(kv[11]),
    .alarm_key(kv[12]), .salarm_key(kv[13]), .zone_busy(zone_busy),
    .busy_prio(busy_prio), .ext_alarm(ext_al), .sys_ready(ready),
    .alarm_active_any(alarm_any), .chime_done(chime_done),
    .text_done(text_done), .ev_kind(ev_kind), .ev_prio(ev_prio),
    .ev_zones(ev_zones), .power_on_req(pwr_req), .music_dim(dim),
    .music_zones(mus_z), .zone_lamp(zone_lamp), .all_lamp(all_lamp),
    .zone_occupied_lamp(occ), .chime_lamp(chime_lamp),
    .text_lamp(text_lamp), .alarm_lamp(alarm_lamp), .music_lamp(mus_lamp),
    .power_lamp(power_lamp));
  pcc_central #(.NZ(NZ)) pcc_central_inst (.clk(clk), .rst(rst),
    .ev_kind(ev_kind), .power_on_req(pwr_req), .busy_set(bz),
    .prio_set(bp), .zone_busy(zone_busy), .busy_prio(busy_prio),
    .sys_ready(ready), .alarm_active_any(alarm_any),
    .chime_done(chime_done), .text_done(text_done));
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  // note an expectation and probe one output group
  task chk(input [1:0] s, input [31:0] e);
  begin
    @(posedge clk);
    probe <= 1'h1;
    psel <= s;
    exp_q.push_back(e);
    @(posedge clk);
    probe <= 1'h0;
  end
  endtask
  // one classic bus cycle; on reads d is the expected word
  task wb(input w, input [7:0] a, input [31:0] d);
  begin
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dwr <= d;
    if (!w)
      exp_q.push_back(d);
    @(posedge clk);
    while (!ack)
      @(posedge clk);
    cyc <= 1'h0;
    stb <= 1'h0;
  end
  endtask
  // short press of one key, then let the state settle
  task tap(input integer k);
  begin
    @(posedge clk);
    kv[k] <= 1'h1;
    repeat (2) @(posedge clk);
    kv[k] <= 1'h0;
    repeat (3) @(posedge clk);
  end
  endtask
  task report_and_stop;
  begin
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  // results are compared whenever a probe or a read answer appears
  always @(posedge clk)
    if (probe || (ack && !we))
    begin
      got = probe ? obs : dat;
      expv = exp_q.pop_front();
      `CHK(got, expv)
    end
  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    report_and_stop;
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    chk(0, IDLE_W);
    chk(3, 0);
    tap(12);
    chk(0, {`PCC_EV_ALARM, `PCC_ALMPRI_RST, 4'hF});
    chk(2, 32'h4);
    tap(12);
    chk(0, IDLE_W);
    repeat (30) @(posedge clk);
    chk(3, 32'hC);
    wb(0, `PCC_OFS_CTRL, {28'h0, `PCC_CTRL_RST});
    wb(1, `PCC_OFS_PRIO, 32'h97);
    wb(0, `PCC_OFS_PRIO, 32'h97);
    // a write without byte lane 0 must leave the priorities alone
    bsel <= 4'hE;
    wb(1, `PCC_OFS_PRIO, 32'h88);
    bsel <= 4'hF;
    wb(0, `PCC_OFS_PRIO, 32'h97);
    wb(1, `PCC_OFS_CTRL, 32'hC);
    wb(0, 8'h40, 32'h0);
    sel = 4'($random(seed));
    sel[1] = 1'h1;
    for (i = 0; i < NZ; i++)
      if (sel[i])
        tap(i);
    chk(1, {sel, &sel});
    tap(0);
    sel[0] = ~sel[0];
    chk(1, {sel, &sel});
    bz <= sel;
    // lower, equal and higher occupying priority
    for (i = 0; i < 3; i++)
    begin
      bp <= 4'h3 + 4'(i) * 4'h2;
      @(posedge clk);
      kv[8] <= 1'h1;
      repeat (4) @(posedge clk);
      chk(0, i == 0 ? {`PCC_EV_CALL, `PCC_PRI_CALL, sel} : IDLE_W);
      if (i == 0)
        chk(3, 32'hF);
      kv[8] <= 1'h0;
      repeat (4) @(posedge clk);
      chk(0, IDLE_W);
      chk(1, {sel, &sel});
      // status blink field: slow for lower, fast for equal or higher
      wb(0, `PCC_OFS_STAT, {24'h0, 3'h2, 3'h0, i == 0 ? 2'h1 : 2'h2});
    end
    bz <= 4'h0;
    tap(6);
    chk(0, {`PCC_EV_CHIME, 4'h7, sel});
    chk(2, 32'h2);
    repeat (40) @(posedge clk);
    chk(0, IDLE_W);
    tap(7);
    chk(0, {`PCC_EV_TEXT, 4'h7, sel});
    tap(10);
    chk(0, IDLE_W);
    tap(5);
    chk(1, 0);
    tap(4);
    chk(1, 32'h1F);
    kv[8] <= 1'h1;
    repeat (4) @(posedge clk);
    chk(0, {`PCC_EV_CALL, `PCC_PRI_CALL, 4'hF});
    // an alarm pre-empts the running call, a second press ends it
    tap(12);
    chk(0, {`PCC_EV_ALARM, 4'h9, 4'hF});
    tap(12);
    kv[8] <= 1'h0;
    // zone 0 as a direct-call key, from an empty selection
    wb(1, `PCC_OFS_ZSEL, 32'h1);
    tap(5);
    kv[0] <= 1'h1;
    repeat (4) @(posedge clk);
    chk(0, {`PCC_EV_CALL, `PCC_PRI_CALL, 4'h1});
    kv[0] <= 1'h0;
    wb(1, `PCC_OFS_CTRL, 32'h2);
    kv[8] <= 1'h1;
    repeat (4) @(posedge clk);
    chk(0, {`PCC_EV_CALL, `PCC_PRI_DIRECTOR, 4'h1});
    kv[8] <= 1'h0;
    wb(1, `PCC_OFS_CTRL, 32'h0);
    // music assignment survives leaving the mode
    tap(11);
    tap(2);
    chk(2, 32'hA0);
    tap(11);
    chk(2, 32'h20);
    tap(9);
    chk(3, 32'hC);
    kv[9] <= 1'h1;
    repeat (30) @(posedge clk);
    kv[9] <= 1'h0;
    repeat (5) @(posedge clk);
    chk(3, 0);
    // an external alarm boots the system and alarms every zone
    ext_al <= 1'h1;
    repeat (4) @(posedge clk);
    chk(0, {`PCC_EV_ALARM, 4'h9, 4'hF});
    report_and_stop;
  end
endmodule // pcc_console_tb_top
